// [port_pwr_consts.svh]
`ifndef PORT_PWR_CONSTS_SVH
`define PORT_PWR_CONSTS_SVH
`define NUM_PORTS 6
`define OC_FILTER_NS 1000
`define CLK_PERIOD_NS 4
`define OC_FILTER_CYCLES ((`OC_FILTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_WIDTH 10
`define PIN_IDLE_LEVEL 1'b1
`define PIN_DRIVE_LEVEL 1'b0
`endif

// [port_pwr_pkg.sv]
`default_nettype none
package port_pwr_pkg;
  typedef logic [5:0] port_vec_t;
  typedef enum logic [1:0] {
    ST_OFF    = 2'b00,
    ST_ON     = 2'b01,
    ST_FAULT  = 2'b10
  } port_state_t;
endpackage
`default_nettype wire

// [oc_filter.sv]
`default_nettype none
`include "port_pwr_consts.svh"
// ==========================================================
// Overcurrent qualifier for one pin
module oc_filter #(
  parameter int FILTER_CYCLES = `OC_FILTER_CYCLES
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic resetn,
  // Control
  input  wire logic sense_en,
  input  wire logic pin_low,
  // Result
  output var  logic oc_active
);
  localparam logic [`CNT_WIDTH-1:0] LIMIT = `CNT_WIDTH'(FILTER_CYCLES - 1);
  logic [`CNT_WIDTH-1:0] cnt_reg;
  wire                   at_limit = (cnt_reg == LIMIT);

  // Short glitches from switch inrush are ignored; only a steady low counts
  always_ff @(posedge sys_clk) begin
    if (!resetn || !sense_en || !pin_low) begin
      cnt_reg   <= '0;
      oc_active <= 1'b0;
    end else if (!at_limit) begin
      cnt_reg   <= cnt_reg + `CNT_WIDTH'(1);
    end else begin
      oc_active <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// [port_power_overcurrent_ctl.sv]
`default_nettype none
`include "port_pwr_consts.svh"
// How it works
// - Outside ganged mode an enabled port's pin is left undriven as an input so the pull-up holds it high.
// - That pulled-up high is the power-on command to the external switch of the port.
// - While a port is enabled outside ganged mode its pin is sampled and a low reads as overcurrent.
// - A port disabled by configuration or by the host has its pin driven low as an output.
// - In ganged mode the shared pin serves as power enable and sense for every port.
module port_power_overcurrent_ctl
#(
  parameter int FILTER_CYCLES = `OC_FILTER_CYCLES
) (
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              resetn,
  // Configuration and host control
  input  wire logic              gang_mode,
  input  wire port_pwr_pkg::port_vec_t cfg_port_en,
  input  wire port_pwr_pkg::port_vec_t host_port_en,
  // Per-port pins, bit 0 is port 1
  input  wire port_pwr_pkg::port_vec_t port_pwr_oc_pin_in,
  output var  port_pwr_pkg::port_vec_t port_pwr_oc_pin_out,
  output var  port_pwr_pkg::port_vec_t port_pwr_oc_pin_oe,
  // Shared pin
  input  wire logic              shared_pwr_oc_pin_in,
  output var  logic              shared_pwr_oc_pin_out,
  output var  logic              shared_pwr_oc_pin_oe,
  // Status
  output var  port_pwr_pkg::port_vec_t port_powered,
  output var  port_pwr_pkg::port_vec_t port_overcurrent
);
  import port_pwr_pkg::*;

  // ==========================================================
  // Helpers
  // One level on every port; the ganged status and pin drive use it
  function automatic port_vec_t fan_out(input logic level);
    fan_out = {`NUM_PORTS{level}};
  endfunction

  // ==========================================================
  // Pin synchronisers
  // Reset to the pull-up level so that no false low follows reset
  port_vec_t pin_meta_reg;
  port_vec_t pin_sync_reg;
  logic      shared_meta_reg;
  logic      shared_sync_reg;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      pin_meta_reg <= {`NUM_PORTS{`PIN_IDLE_LEVEL}};
      pin_sync_reg <= {`NUM_PORTS{`PIN_IDLE_LEVEL}};
    end else begin
      pin_meta_reg <= port_pwr_oc_pin_in;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      shared_meta_reg <= `PIN_IDLE_LEVEL;
      shared_sync_reg <= `PIN_IDLE_LEVEL;
    end else begin
      shared_meta_reg <= shared_pwr_oc_pin_in;
      shared_sync_reg <= shared_meta_reg;
    end
  end

  // ==========================================================
  // Enable decode
  port_vec_t port_en;
  port_vec_t port_released;
  port_vec_t port_sense_en;
  logic      any_en;
  logic      gang_en;
  logic      shared_released;
  logic      shared_sense_en;

  assign port_en         = cfg_port_en & host_port_en;
  assign any_en          = |port_en;
  // Ganged switch is powered while any port wants power
  assign gang_en         = gang_mode && any_en;
  // Pins count as released only once the registered drive has let go
  assign port_released   = ~port_pwr_oc_pin_oe;
  assign shared_released = !shared_pwr_oc_pin_oe;
  // Our own low drive must not read as a fault when a port comes on.
  // Two stale synchroniser samples still reach the filter, so it must
  // be set to more than two cycles.
  assign port_sense_en   = gang_mode ? fan_out(1'b0) : (port_en & port_released);
  assign shared_sense_en = gang_en && shared_released;

  // ==========================================================
  // Overcurrent qualification
  port_vec_t oc_raw;
  logic      shared_oc;

  for (genvar i = 0; i < `NUM_PORTS; i++) begin : g_port
    oc_filter #(.FILTER_CYCLES(FILTER_CYCLES)) u_filt (
      .sys_clk   (sys_clk),
      .resetn    (resetn),
      .sense_en  (port_sense_en[i]),
      .pin_low   (!pin_sync_reg[i]),
      .oc_active (oc_raw[i])
    );
  end

  oc_filter #(.FILTER_CYCLES(FILTER_CYCLES)) u_filt_shared (
    .sys_clk   (sys_clk),
    .resetn    (resetn),
    .sense_en  (shared_sense_en),
    .pin_low   (!shared_sync_reg),
    .oc_active (shared_oc)
  );

  // ==========================================================
  // Pin drive and status
  port_vec_t pin_oe_next;
  port_vec_t pin_out_next;
  port_vec_t powered_next;
  port_vec_t oc_next;
  logic      shared_oe_next;
  logic      shared_out_next;

  // Disabled pin drives low; enabled pin floats to the pull-up; in ganged mode every per-port pin drives low
  assign pin_oe_next     = gang_mode ? fan_out(1'b1) : ~port_en;
  // Open-drain style: a high only ever comes from the pull-up
  assign pin_out_next    = fan_out(`PIN_DRIVE_LEVEL);
  assign shared_oe_next  = !gang_en;
  assign shared_out_next = `PIN_DRIVE_LEVEL;
  // Pull-up high is the switch's on command
  assign powered_next    = gang_mode ? fan_out(gang_en) : port_en;
  // One shared fault hits every port; not latched, switching off is up to firmware
  assign oc_next         = gang_mode ? fan_out(shared_oc) : oc_raw;

  // Per-port pins; reset drives all low so no switch turns on early
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      port_pwr_oc_pin_out <= fan_out(`PIN_DRIVE_LEVEL);
      port_pwr_oc_pin_oe  <= fan_out(1'b1);
    end else begin
      port_pwr_oc_pin_out <= pin_out_next;
      port_pwr_oc_pin_oe  <= pin_oe_next;
    end
  end

  // Shared pin
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      shared_pwr_oc_pin_out <= `PIN_DRIVE_LEVEL;
      shared_pwr_oc_pin_oe  <= 1'b1;
    end else begin
      shared_pwr_oc_pin_out <= shared_out_next;
      shared_pwr_oc_pin_oe  <= shared_oe_next;
    end
  end

  // Status
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      port_powered     <= fan_out(1'b0);
      port_overcurrent <= fan_out(1'b0);
    end else begin
      port_powered     <= powered_next;
      port_overcurrent <= oc_next;
    end
  end
endmodule
`default_nettype wire

// [port_pwr_switch_model.sv]
`default_nettype none
module port_pwr_switch_model import port_pwr_pkg::*; (
  input  wire port_vec_t pin_oe, pin_out, oc_req,
  input  wire logic      shared_oe, shared_out,
  output var  port_vec_t pin,
  output var  logic      shared_pin
);
  // ======
  // Pull-up wins unless the pin is driven or a monitor pulls low
  assign pin = (pin_oe & pin_out) | (~pin_oe & ~oc_req);
  assign shared_pin = shared_oe ? shared_out : ~|oc_req;
endmodule
`default_nettype wire

// [port_pwr_chk.sv]
`default_nettype none
module port_pwr_chk import port_pwr_pkg::*; #(parameter int FILTER_CYCLES = 4) (
  input wire logic      sys_clk, resetn, gang_mode, shared_pwr_oc_pin_in,
  input wire logic      shared_pwr_oc_pin_out, shared_pwr_oc_pin_oe,
  input wire port_vec_t cfg_port_en, host_port_en, port_pwr_oc_pin_in,
  input wire port_vec_t port_pwr_oc_pin_out, port_pwr_oc_pin_oe,
  input wire port_vec_t port_powered, port_overcurrent
);
  // ======
  // Properties
  wire port_vec_t en = cfg_port_en & host_port_en;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  sequence oc_low; !gang_mode && en[0] && !port_pwr_oc_pin_in[0]; endsequence
  sequence gang_low; gang_mode && |en && !shared_pwr_oc_pin_in; endsequence
  a_pin_release: assert property (!gang_mode |=> port_pwr_oc_pin_oe == ~$past(en))
    else $error("oe");
  a_power_on: assert property (!gang_mode |=> port_powered == $past(en))
    else $error("pwr");
  a_drive_low: assert property (!(|port_pwr_oc_pin_out || shared_pwr_oc_pin_out))
    else $error("out");
  a_oc_sense: assert property (oc_low[*8] |-> ##[0:8] port_overcurrent[0])
    else $error("oc set");
  a_oc_clear: assert property ((port_pwr_oc_pin_in[0] && !gang_mode)[*5] |-> !port_overcurrent[0])
    else $error("oc clr");
  a_gang_pins: assert property (gang_mode |=> &port_pwr_oc_pin_oe)
    else $error("gang oe");
  a_gang_share: assert property (gang_mode && |en |=> !shared_pwr_oc_pin_oe)
    else $error("shared oe");
  a_gang_all: assert property (gang_low[*8] |-> ##[0:8] &port_overcurrent)
    else $error("gang oc");
endmodule
bind port_power_overcurrent_ctl port_pwr_chk #(.FILTER_CYCLES(FILTER_CYCLES)) chk (.*);
`default_nettype wire

// [tb_port_power_overcurrent_ctl.sv]
`default_nettype none
module tb_port_power_overcurrent_ctl;
  timeunit 1ns;
  timeprecision 1ps;
  import port_pwr_pkg::*;
  logic      sys_clk = 0, resetn = 0, gang = 0, sh_in, sh_out, sh_oe;
  port_vec_t cfg = '1, host = '0, oc = '0, pin, p_out, p_oe, pwr, ovc;
  int        err_count = 0, n_tests = 0;
  always #2 sys_clk = ~sys_clk;
  port_power_overcurrent_ctl #(.FILTER_CYCLES(4)) dut (.sys_clk(sys_clk), .resetn(resetn),
    .gang_mode(gang), .cfg_port_en(cfg), .host_port_en(host), .port_pwr_oc_pin_in(pin),
    .port_pwr_oc_pin_out(p_out), .port_pwr_oc_pin_oe(p_oe), .shared_pwr_oc_pin_in(sh_in),
    .shared_pwr_oc_pin_out(sh_out), .shared_pwr_oc_pin_oe(sh_oe), .port_powered(pwr),
    .port_overcurrent(ovc));
  port_pwr_switch_model sw (.pin_oe(p_oe), .pin_out(p_out), .oc_req(oc),
    .shared_oe(sh_oe), .shared_out(sh_out), .pin(pin), .shared_pin(sh_in));
  // ======
  // Checks and scenarios
  task automatic chk(input port_vec_t got, exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic w(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task final_report;
    $display("errors=%0d tests=%0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic t_enable;
    port_vec_t pat[3] = '{6'h00, 6'h2d, 6'h3f};
    foreach (pat[i]) begin
      cfg = 6'h3b;
      host = pat[i];
      w(2);
      chk(p_oe, ~(pat[i] & 6'h3b));
      chk(pwr, pat[i] & 6'h3b);
      chk(p_out, 6'h00);
    end
  endtask
  task automatic t_oc;
    cfg = 6'h3f;
    oc = 6'h01;
    w(2);
    oc = 6'h00;
    w(12);
    chk(ovc, 6'h00);
    oc = 6'h21;
    w(16);
    chk(ovc, 6'h21);
    oc = 6'h00;
    w(4);
    chk(ovc, 6'h00);
  endtask
  task automatic t_gang;
    gang = 1;
    w(4);
    chk(p_oe, 6'h3f);
    chk({5'h00, sh_oe}, 6'h00);
    chk({5'h00, sh_out}, 6'h00);
    oc = 6'h04;
    w(16);
    chk(ovc, 6'h3f);
    oc = 6'h00;
    host = 6'h00;
    w(4);
    chk({5'h00, sh_oe}, 6'h01);
  endtask
  task automatic t_reset;
    gang = 0;
    host = 6'h3f;
    oc   = 6'h01;
    w(16);
    chk(ovc, 6'h01);
    resetn = 0;
    w(2);
    chk(p_oe, 6'h3f);
    chk(pwr, 6'h00);
    chk(ovc, 6'h00);
    chk({5'h00, sh_oe}, 6'h01);
    chk({5'h00, sh_out}, 6'h00);
    resetn = 1;
    w(2);
    chk(p_oe, 6'h00);
    chk(pwr, 6'h3f);
    w(12);
    chk(ovc, 6'h01);
    oc = 6'h00;
    w(4);
    chk(ovc, 6'h00);
  endtask
  initial begin
    w(3);
    resetn = 1;
    t_enable;
    t_oc;
    t_gang;
    t_reset;
    final_report;
  end
  // Run needs about 100 cycles
  initial begin
    #2000;
    err_count++;
    final_report;
  end
endmodule
`default_nettype wire
